//--- design/lkbd_trap.sv
// Legacy keyboard/mouse port trap, pass-through detector and interrupt steering.
// Assumes config and I/O strobes are one-cycle pulses on CLK_SYS; the line D pin is asynchronous.
`timescale 1ns/1ns
`default_nettype none

module lkbd_trap
(
    input wire logic CLK_SYS,
    input wire logic RST_B,
    input wire logic CFG_WR,
    input wire logic CFG_RD,
    input wire logic [7:0] CFG_ADDR,
    input wire logic [1:0] CFG_BE,
    input wire logic [15:0] CFG_WDATA,
    output logic [15:0] CFG_RDATA,
    output logic CFG_RACK,
    input wire logic IO_WR,
    input wire logic IO_RD,
    input wire logic [15:0] IO_ADDR,
    input wire logic [7:0] IO_WDATA,
    input wire logic HOST_IRQ,
    input wire logic PCI_IRQ_LINE_D_N,
    output logic SYS_IRQ_LINE_D,
    output logic SYS_MGMT_INTR_N,
    output logic ADDR_BIT20_GATE
);
    import lkbd_pkg::*;

    typedef struct packed {
        logic end_sts;
        logic route_en;
        logic cmd_wr_sts;
        logic cmd_rd_sts;
        logic dat_wr_sts;
        logic dat_rd_sts;
        logic end_en;
        logic pt_en;
        logic irq_en;
        logic cmd_wr_en;
        logic cmd_rd_en;
        logic dat_wr_en;
        logic dat_rd_en;
        lkbd_pt_state_t pt_state;
        logic gate;
        logic smi_n;
        logic irq_d;
        logic [15:0] rdata;
        logic rack;
        logic pirq_s1;
        logic pirq_s2;
    } lkbd_state_t;

    lkbd_state_t st_q;
    lkbd_state_t st_d;

    // Sticky status: a hardware set in the same cycle as a clear wins
    function automatic logic sticky(input logic cur, input logic set, input logic clr);
        sticky = set | (cur & ~clr);
    endfunction : sticky

    logic cfg_hit;
    logic wr_lo;
    logic wr_hi;
    logic cmd_wr;
    logic cmd_rd;
    logic dat_wr;
    logic dat_rd;
    logic part_of_seq;
    logic seq_end;
    logic any_event;
    logic [15:0] rd_word;

    always_comb
    begin
        st_d = st_q;
        cfg_hit = (CFG_ADDR[7:1] == LKBD_CFG_OFFSET[7:1]);
        wr_lo = CFG_WR & cfg_hit & CFG_BE[0];
        wr_hi = CFG_WR & cfg_hit & CFG_BE[1];
        cmd_wr = IO_WR & (IO_ADDR == LKBD_CMD_PORT);
        cmd_rd = IO_RD & (IO_ADDR == LKBD_CMD_PORT);
        dat_wr = IO_WR & (IO_ADDR == LKBD_DATA_PORT);
        dat_rd = IO_RD & (IO_ADDR == LKBD_DATA_PORT);
        part_of_seq = 1'b0;
        seq_end = 1'b0;

        // Pin input passes two flops before use
        st_d.pirq_s1 = ~PCI_IRQ_LINE_D_N;
        st_d.pirq_s2 = st_q.pirq_s1;

        // Pass-through detector; other ports are ignored and do not break a sequence
        unique case (st_q.pt_state)
            PT_IDLE:
            begin
                if (st_q.pt_en && cmd_wr && IO_WDATA == LKBD_CMD_GATE)
                begin
                    st_d.pt_state = PT_GOT_CMD;
                    part_of_seq = 1'b1;
                end
            end
            PT_GOT_CMD:
            begin
                if (cmd_wr && IO_WDATA == LKBD_CMD_GATE)
                begin
                    part_of_seq = 1'b1;
                end
                else if (dat_wr)
                begin
                    st_d.pt_state = PT_GOT_DATA;
                    st_d.gate = IO_WDATA[LKBD_GATE_BIT];
                    part_of_seq = 1'b1;
                end
                else if (cmd_wr || cmd_rd || dat_rd)
                begin
                    st_d.pt_state = PT_IDLE;
                    seq_end = 1'b1;
                end
            end
            PT_GOT_DATA:
            begin
                if (cmd_rd)
                begin
                    part_of_seq = 1'b1;
                end
                else if (cmd_wr && IO_WDATA == LKBD_CMD_END)
                begin
                    st_d.pt_state = PT_IDLE;
                    part_of_seq = 1'b1;
                    seq_end = 1'b1;
                end
                else if (cmd_wr || dat_wr || dat_rd)
                begin
                    st_d.pt_state = PT_IDLE;
                    seq_end = 1'b1;
                end
            end
        endcase

        // Clearing the enable aborts at once; the abort counts as an end
        if (wr_lo && !CFG_WDATA[BIT_PT_EN] && st_q.pt_state != PT_IDLE)
        begin
            st_d.pt_state = PT_IDLE;
            seq_end = 1'b1;
        end

        // Control bits
        if (wr_lo)
        begin
            st_d.end_en = CFG_WDATA[BIT_END_EN];
            st_d.pt_en = CFG_WDATA[BIT_PT_EN];
            st_d.irq_en = CFG_WDATA[BIT_IRQ_EN];
            st_d.cmd_wr_en = CFG_WDATA[BIT_CMD_WR_EN];
            st_d.cmd_rd_en = CFG_WDATA[BIT_CMD_RD_EN];
            st_d.dat_wr_en = CFG_WDATA[BIT_DAT_WR_EN];
            st_d.dat_rd_en = CFG_WDATA[BIT_DAT_RD_EN];
        end
        if (wr_hi)
        begin
            st_d.route_en = CFG_WDATA[BIT_ROUTE_EN];
        end

        // Trap status; sequence members are not recorded
        st_d.end_sts = sticky(st_q.end_sts, seq_end, wr_hi & CFG_WDATA[BIT_END_STS]);
        st_d.cmd_wr_sts = sticky(st_q.cmd_wr_sts, cmd_wr & ~part_of_seq,
                                 wr_hi & CFG_WDATA[BIT_CMD_WR_STS]);
        st_d.cmd_rd_sts = sticky(st_q.cmd_rd_sts, cmd_rd & ~part_of_seq,
                                 wr_hi & CFG_WDATA[BIT_CMD_RD_STS]);
        st_d.dat_wr_sts = sticky(st_q.dat_wr_sts, dat_wr & ~part_of_seq,
                                 wr_hi & CFG_WDATA[BIT_DAT_WR_STS]);
        st_d.dat_rd_sts = sticky(st_q.dat_rd_sts, dat_rd & ~part_of_seq,
                                 wr_hi & CFG_WDATA[BIT_DAT_RD_STS]);

        // Trap and end status hold the interrupt until software clears them; the host request source is passed live
        any_event = (st_q.cmd_wr_sts & st_q.cmd_wr_en)
                  | (st_q.cmd_rd_sts & st_q.cmd_rd_en)
                  | (st_q.dat_wr_sts & st_q.dat_wr_en)
                  | (st_q.dat_rd_sts & st_q.dat_rd_en)
                  | (HOST_IRQ & st_q.irq_en)
                  | (st_q.end_sts & st_q.end_en);
        st_d.smi_n = ~(any_event & (st_q.pt_state == PT_IDLE));

        st_d.irq_d = (HOST_IRQ & st_q.route_en) | st_q.pirq_s2;

        // Register read view; bit 14 reserved reads zero
        rd_word = '0;
        rd_word[BIT_END_STS] = st_q.end_sts;
        rd_word[BIT_ROUTE_EN] = st_q.route_en;
        rd_word[BIT_IRQ_STS] = HOST_IRQ;
        rd_word[BIT_CMD_WR_STS] = st_q.cmd_wr_sts;
        rd_word[BIT_CMD_RD_STS] = st_q.cmd_rd_sts;
        rd_word[BIT_DAT_WR_STS] = st_q.dat_wr_sts;
        rd_word[BIT_DAT_RD_STS] = st_q.dat_rd_sts;
        rd_word[BIT_END_EN] = st_q.end_en;
        rd_word[BIT_IN_PROG] = (st_q.pt_state != PT_IDLE);
        rd_word[BIT_PT_EN] = st_q.pt_en;
        rd_word[BIT_IRQ_EN] = st_q.irq_en;
        rd_word[BIT_CMD_WR_EN] = st_q.cmd_wr_en;
        rd_word[BIT_CMD_RD_EN] = st_q.cmd_rd_en;
        rd_word[BIT_DAT_WR_EN] = st_q.dat_wr_en;
        rd_word[BIT_DAT_RD_EN] = st_q.dat_rd_en;

        st_d.rack = CFG_RD;
        if (CFG_RD)
        begin
            // Unmapped offsets answer zero so neighbouring registers are not aliased
            st_d.rdata = cfg_hit ? rd_word : '0;
        end
    end

    always_ff @(posedge CLK_SYS or negedge RST_B)
    begin
        if (!RST_B)
        begin
            st_q <= '0;
            st_q.route_en <= LKBD_CFG_RESET[BIT_ROUTE_EN];
            st_q.pt_state <= PT_IDLE;
            st_q.gate <= LKBD_GATE_RESET;
            st_q.smi_n <= 1'b1;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign CFG_RDATA = st_q.rdata;
    assign CFG_RACK = st_q.rack;
    assign SYS_IRQ_LINE_D = st_q.irq_d;
    assign SYS_MGMT_INTR_N = st_q.smi_n;
    assign ADDR_BIT20_GATE = st_q.gate;

endmodule : lkbd_trap

`default_nettype wire

//--- design/lkbd_pkg.sv
// Constants, field positions and types for the legacy keyboard trap block.
// Assumes a single system clock domain and one 16-bit configuration word.
// Contract
// - Pass-through end status sets at sequence end; cleared by writing 1.
// - Bit 13 set routes host interrupt to line D; resets to 1.
// - Bit 12 read-only, shows host interrupt request; writes ignored.
// - Write to port 64h sets bit 11; write 1 clears.
// - Read of port 64h sets bit 10; write 1 clears.
// - Write to port 60h sets bit 9; write 1 clears.
// - Read of port 60h sets bit 8; write 1 clears.
// - Bit 7 enables management interrupt at pass-through end; default 0.
// - Bit 6 read-only, 1 while pass-through sequence runs; resets 0.
// - Writing 0 to bit 5 ends any running sequence immediately.
// - Sequence: D1h writes to 64h, 60h write, 64h reads, FFh to 64h.
// - Out-of-order access leaves sequence and is handled as normal access.
// - No management interrupt while a pass-through sequence is underway.
// - Accesses inside a recognised sequence set no trap status.
// - Bit 4 enables management interrupt on host interrupt request.
// - Bit 3 enables trap and interrupt on port 64h writes; the code gates only the interrupt, bit 11 sets regardless.
// - Bit 2 enables trap and interrupt on port 64h reads; the code gates only the interrupt, bit 10 sets regardless.
// - Bit 1 enables trap and interrupt on port 60h writes; the code gates only the interrupt, bit 9 sets regardless.
// - Bit 0 enables trap and interrupt on port 60h reads; the code gates only the interrupt, bit 8 sets regardless.
// - Host interrupt is ORed with line D toward the interrupt controller.

package lkbd_pkg;

    localparam logic [7:0] LKBD_CFG_OFFSET = 8'hc0;
    localparam logic [15:0] LKBD_CFG_RESET = 16'h2000;

    localparam int unsigned BIT_END_STS = 15;
    localparam int unsigned BIT_ROUTE_EN = 13;
    localparam int unsigned BIT_IRQ_STS = 12;
    localparam int unsigned BIT_CMD_WR_STS = 11;
    localparam int unsigned BIT_CMD_RD_STS = 10;
    localparam int unsigned BIT_DAT_WR_STS = 9;
    localparam int unsigned BIT_DAT_RD_STS = 8;
    localparam int unsigned BIT_END_EN = 7;
    localparam int unsigned BIT_IN_PROG = 6;
    localparam int unsigned BIT_PT_EN = 5;
    localparam int unsigned BIT_IRQ_EN = 4;
    localparam int unsigned BIT_CMD_WR_EN = 3;
    localparam int unsigned BIT_CMD_RD_EN = 2;
    localparam int unsigned BIT_DAT_WR_EN = 1;
    localparam int unsigned BIT_DAT_RD_EN = 0;

    localparam logic [15:0] LKBD_CMD_PORT = 16'h0064;
    localparam logic [15:0] LKBD_DATA_PORT = 16'h0060;
    localparam logic [7:0] LKBD_CMD_GATE = 8'hd1;
    localparam logic [7:0] LKBD_CMD_END = 8'hff;
    localparam int unsigned LKBD_GATE_BIT = 1;
    localparam logic LKBD_GATE_RESET = 1'b0;

    typedef enum logic [1:0] {
        PT_IDLE,
        PT_GOT_CMD,
        PT_GOT_DATA
    } lkbd_pt_state_t;

endpackage : lkbd_pkg

//--- verif/lkbd_host.sv
// Host model: issues config and I/O cycles toward the trap block.
// Assumes the bench calls its tasks; it drives on falling edges of CLK_SYS.
`timescale 1ns/1ns
`default_nettype none
module lkbd_host
(
    input wire logic CLK_SYS,
    input wire logic CFG_RACK,
    input wire logic [15:0] CFG_RDATA,
    output logic CFG_WR,
    output logic CFG_RD,
    output logic [7:0] CFG_ADDR,
    output logic [1:0] CFG_BE,
    output logic [15:0] CFG_WDATA,
    output logic IO_WR,
    output logic IO_RD,
    output logic [15:0] IO_ADDR,
    output logic [7:0] IO_WDATA
);
    initial
    begin
        {CFG_WR, CFG_RD, IO_WR, IO_RD} = 4'h0;
        {CFG_ADDR, CFG_BE, CFG_WDATA, IO_ADDR, IO_WDATA} = '0;
    end
    // Released lines show inverted values so stale data cannot pass for a match
    task automatic cfg(input logic wr, input logic [7:0] a, input logic [1:0] be, input logic [15:0] d,
        output logic [15:0] q);
        @(negedge CLK_SYS);
        {CFG_WR, CFG_RD, CFG_ADDR, CFG_BE, CFG_WDATA} = {wr, !wr, a, be, d};
        @(negedge CLK_SYS);
        for (int n = 0; n < 4 && !wr && CFG_RACK !== 1'b1; n++)
            @(negedge CLK_SYS);
        q = CFG_RDATA;
        {CFG_WR, CFG_RD, CFG_ADDR, CFG_BE, CFG_WDATA} = {2'b00, ~a, ~be, ~d};
    endtask : cfg
    task automatic io(input logic wr, input logic [15:0] a, input logic [7:0] d);
        @(negedge CLK_SYS);
        {IO_WR, IO_RD, IO_ADDR, IO_WDATA} = {wr, !wr, a, d};
        @(negedge CLK_SYS);
        {IO_WR, IO_RD, IO_ADDR, IO_WDATA} = {2'b00, ~a, ~d};
    endtask : io
endmodule : lkbd_host
`default_nettype wire

//--- verif/lkbd_trap_assertions.sv
// Port checker for the trap block, bound into every lkbd_trap.
// Assumes one clock domain with the async active-low reset.
`timescale 1ns/1ns
`default_nettype none
module lkbd_trap_chk
(
    input wire logic CLK_SYS,
    input wire logic RST_B,
    input wire logic CFG_WR,
    input wire logic CFG_RD,
    input wire logic [7:0] CFG_ADDR,
    input wire logic CFG_RACK,
    input wire logic [15:0] CFG_RDATA,
    input wire logic IO_WR,
    input wire logic IO_RD,
    input wire logic [15:0] IO_ADDR,
    input wire logic [7:0] IO_WDATA,
    input wire logic HOST_IRQ,
    input wire logic PCI_IRQ_LINE_D_N,
    input wire logic SYS_IRQ_LINE_D,
    input wire logic SYS_MGMT_INTR_N,
    input wire logic ADDR_BIT20_GATE
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!RST_B);
    // Four samples cover the two sync flops plus the output flop
    sequence s_line_low; (!PCI_IRQ_LINE_D_N)[*4]; endsequence
    sequence s_line_idle; (PCI_IRQ_LINE_D_N && !HOST_IRQ)[*4]; endsequence
    AST_READ_ANSWER: assert property (CFG_RD |=> CFG_RACK)
        else $error("read not answered");
    AST_NO_STRAY_ANSWER: assert property (CFG_RACK |-> $past(CFG_RD))
        else $error("answer without read");
    // Unmapped offsets answer zero, so only reads of our own word carry the live bit
    AST_IRQ_STATUS_LIVE: assert property (CFG_RACK && $past(CFG_ADDR[7:1] == 7'h60)
        |-> CFG_RDATA[12] == $past(HOST_IRQ))
        else $error("irq status bit wrong");
    AST_QUIET_IN_SEQUENCE: assert property (CFG_RACK && CFG_RDATA[6] |-> SYS_MGMT_INTR_N)
        else $error("interrupt during sequence");
    AST_LINE_D_OR: assert property (s_line_low |-> SYS_IRQ_LINE_D)
        else $error("line D not passed");
    AST_LINE_D_IDLE: assert property (s_line_idle |-> !SYS_IRQ_LINE_D)
        else $error("line D without cause");
    AST_GATE_FROM_DATA: assert property ($rose(ADDR_BIT20_GATE) |->
        $past(IO_WR && IO_ADDR == 16'h0060 && IO_WDATA[1]))
        else $error("gate rose without data write");
    AST_SMI_HAS_CAUSE: assert property ($fell(SYS_MGMT_INTR_N) |-> $past(HOST_IRQ) || $past(CFG_WR)
        || $past(CFG_WR, 2) || $past(IO_WR || IO_RD, 2))
        else $error("interrupt without cause");
endmodule : lkbd_trap_chk
bind lkbd_trap lkbd_trap_chk lkbd_trap_chk_i (.CLK_SYS(CLK_SYS), .RST_B(RST_B), .CFG_WR(CFG_WR),
    .CFG_RD(CFG_RD), .CFG_ADDR(CFG_ADDR), .CFG_RACK(CFG_RACK), .CFG_RDATA(CFG_RDATA), .IO_WR(IO_WR), .IO_RD(IO_RD),
    .IO_ADDR(IO_ADDR), .IO_WDATA(IO_WDATA), .HOST_IRQ(HOST_IRQ), .PCI_IRQ_LINE_D_N(PCI_IRQ_LINE_D_N),
    .SYS_IRQ_LINE_D(SYS_IRQ_LINE_D), .SYS_MGMT_INTR_N(SYS_MGMT_INTR_N), .ADDR_BIT20_GATE(ADDR_BIT20_GATE));
`default_nettype wire

//--- verif/lkbd_trap_test.sv
// Self-checking bench for the trap block, driven through the host model.
// Assumes the package constants and a 25 MHz system clock.
`timescale 1ns/1ns
`default_nettype none
module lkbd_trap_test;
    import lkbd_pkg::*;
    logic CLK_SYS = 1'b0;
    logic RST_B, CFG_WR, CFG_RD, CFG_RACK, IO_WR, IO_RD, HOST_IRQ, PCI_IRQ_LINE_D_N;
    logic SYS_IRQ_LINE_D, SYS_MGMT_INTR_N, ADDR_BIT20_GATE;
    logic [7:0] CFG_ADDR, IO_WDATA;
    logic [1:0] CFG_BE;
    logic [15:0] CFG_WDATA, CFG_RDATA, IO_ADDR;
    int miscompares = 0;
    int num_checks = 0;
    int cycles = 0;
    always #20 CLK_SYS = ~CLK_SYS;
    lkbd_trap lkbd_trap_i (.CLK_SYS(CLK_SYS), .RST_B(RST_B), .CFG_WR(CFG_WR), .CFG_RD(CFG_RD),
        .CFG_ADDR(CFG_ADDR), .CFG_BE(CFG_BE), .CFG_WDATA(CFG_WDATA), .CFG_RDATA(CFG_RDATA),
        .CFG_RACK(CFG_RACK), .IO_WR(IO_WR), .IO_RD(IO_RD), .IO_ADDR(IO_ADDR), .IO_WDATA(IO_WDATA),
        .HOST_IRQ(HOST_IRQ), .PCI_IRQ_LINE_D_N(PCI_IRQ_LINE_D_N), .SYS_IRQ_LINE_D(SYS_IRQ_LINE_D),
        .SYS_MGMT_INTR_N(SYS_MGMT_INTR_N), .ADDR_BIT20_GATE(ADDR_BIT20_GATE));
    lkbd_host lkbd_host_i (.CLK_SYS(CLK_SYS), .CFG_RACK(CFG_RACK), .CFG_RDATA(CFG_RDATA),
        .CFG_WR(CFG_WR), .CFG_RD(CFG_RD), .CFG_ADDR(CFG_ADDR), .CFG_BE(CFG_BE), .CFG_WDATA(CFG_WDATA),
        .IO_WR(IO_WR), .IO_RD(IO_RD), .IO_ADDR(IO_ADDR), .IO_WDATA(IO_WDATA));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic pin(input logic got, input logic exp);
        chk({15'h0000, got}, {15'h0000, exp});
    endtask : pin
    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        logic [15:0] q;
        lkbd_host_i.cfg(1'b0, a, 2'b11, 16'h0000, q);
        chk(q, exp);
    endtask : rd
    task automatic wr(input logic [1:0] be, input logic [15:0] d);
        logic [15:0] q;
        lkbd_host_i.cfg(1'b1, 8'hc0, be, d, q);
    endtask : wr
    task automatic done(input string s);
        repeat (3) @(negedge CLK_SYS);
        $display("test %s done", s);
    endtask : done
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : finish_test
    // Whole run needs well under 1000 cycles
    always @(posedge CLK_SYS)
    begin
        cycles <= cycles + 1;
        if (cycles == 4000)
        begin
            miscompares++;
            finish_test();
        end
    end
    initial
    begin
        {RST_B, HOST_IRQ, PCI_IRQ_LINE_D_N} = 3'b001;
        repeat (10) @(negedge CLK_SYS);
        RST_B = 1'b1;
        rd(8'hc0, 16'h2000);
        rd(8'h40, 16'h0000);
        done("reset");
        for (int k = 0; k < 4; k++)
        begin
            wr(2'b11, 16'h2000 | (16'h0001 << k));
            lkbd_host_i.io(k[0], k[1] ? LKBD_CMD_PORT : LKBD_DATA_PORT, 8'h00);
            done("trap");
            pin(SYS_MGMT_INTR_N, 1'b0);
            rd(8'hc0, 16'h2000 | (16'h0101 << k));
            wr(2'b11, 16'h2000 | (16'h0100 << k));
            done("clear");
            pin(SYS_MGMT_INTR_N, 1'b1);
        end
        HOST_IRQ = 1'b1;
        done("irq");
        pin(SYS_IRQ_LINE_D, 1'b1);
        wr(2'b11, 16'h3010);
        done("irq enable");
        pin(SYS_MGMT_INTR_N, 1'b0);
        rd(8'hc0, 16'h3010);
        wr(2'b11, 16'h0010);
        done("route off");
        pin(SYS_IRQ_LINE_D, 1'b0);
        PCI_IRQ_LINE_D_N = 1'b0;
        done("line d");
        pin(SYS_IRQ_LINE_D, 1'b1);
        {HOST_IRQ, PCI_IRQ_LINE_D_N} = 2'b01;
        wr(2'b11, 16'h20af);
        lkbd_host_i.io(1'b1, LKBD_CMD_PORT, LKBD_CMD_GATE);
        lkbd_host_i.io(1'b1, LKBD_CMD_PORT, LKBD_CMD_GATE);
        rd(8'hc0, 16'h20ef);
        pin(SYS_MGMT_INTR_N, 1'b1);
        lkbd_host_i.io(1'b1, LKBD_DATA_PORT, 8'h02);
        lkbd_host_i.io(1'b0, LKBD_CMD_PORT, 8'h00);
        lkbd_host_i.io(1'b1, LKBD_CMD_PORT, LKBD_CMD_END);
        done("sequence");
        rd(8'hc0, 16'ha0af);
        pin(ADDR_BIT20_GATE, 1'b1);
        pin(SYS_MGMT_INTR_N, 1'b0);
        wr(2'b11, 16'ha0af);
        lkbd_host_i.io(1'b1, LKBD_CMD_PORT, LKBD_CMD_GATE);
        lkbd_host_i.io(1'b0, LKBD_DATA_PORT, 8'h00);
        done("deviation");
        rd(8'hc0, 16'ha1af);
        wr(2'b11, 16'ha1af);
        lkbd_host_i.io(1'b1, LKBD_CMD_PORT, LKBD_CMD_GATE);
        wr(2'b01, 16'hff8f);
        done("abort");
        rd(8'hc0, 16'ha08f);
        finish_test();
    end
endmodule : lkbd_trap_test
`default_nettype wire
